// ===== rtl/csv_pkg.sv
// Purpose: shared constants for the status, stack and vectoring core
// Assumes: 6-bit I/O space, 12-bit program addresses
// Notes:   bit positions of the flag word and stack step sizes live here
package csv_pkg;
    // I/O locations
    localparam logic [5:0]  ADDR_STACK_PTR = 6'h3D;
    localparam logic [5:0]  ADDR_FLAG_WORD = 6'h3F;
    // flag word bit positions
    localparam int          BIT_CARRY      = 0;
    localparam int          BIT_ZERO       = 1;
    localparam int          BIT_NEG        = 2;
    localparam int          BIT_OVER       = 3;
    localparam int          BIT_SIGN       = 4;
    localparam int          BIT_HALF       = 5;
    localparam int          BIT_COPY       = 6;
    localparam int          BIT_GATE       = 7;
    // reset values
    localparam logic [7:0]  FLAG_RESET     = 8'h00;
    localparam logic [7:0]  SP_RESET       = 8'h00;
    localparam logic [7:0]  READ_NONE      = 8'h00;
    // stack steps: one byte of data or a two-byte return address
    localparam logic [7:0]  STEP_BYTE      = 8'h01;
    localparam logic [7:0]  STEP_ADDR      = 8'h02;
    // vectors
    localparam int          NUM_SOURCES    = 13;
    localparam int          PC_W           = 12;
    localparam logic [11:0] VEC_RESET      = 12'h000;
    localparam logic [11:0] VEC_FIRST      = 12'h001;

    typedef enum logic [0:0] {CS_RESTART, CS_RUN} csv_state_type;
endpackage

// ===== rtl/csv_stack_if.sv
// Purpose: carries stack pointer events from the core to the pointer unit
// Assumes: at most one move event per cycle; a register write wins
// Notes:   sp is the registered pointer value
`timescale 1ns/1ps
interface csv_stack_if;
    logic       wrEn;
    logic [7:0] wrData;
    logic       decByte;
    logic       decAddr;
    logic       incByte;
    logic       incAddr;
    logic [7:0] sp;

    modport core  (output wrEn, wrData, decByte, decAddr, incByte, incAddr, input sp);
    modport stack (input wrEn, wrData, decByte, decAddr, incByte, incAddr, output sp);
endinterface

// ===== rtl/csv_stack_ptr.sv
// Purpose: 8-bit stack pointer that moves on push, pop, call and return
// Assumes: the core raises at most one move event per cycle
// Notes:   a software write in the same cycle as a move takes precedence
`timescale 1ns/1ps
module csv_stack_ptr (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // events from the core
    csv_stack_if.stack   stk
);
    logic [7:0] sp_reg;
    logic [7:0] sp_next;

    // pointer move; wraps silently, software keeps it above the data area
    always_comb begin
        sp_next = sp_reg;
        if (stk.wrEn) begin
            sp_next = stk.wrData;
        end else if (stk.decAddr) begin
            sp_next = sp_reg - csv_pkg::STEP_ADDR;
        end else if (stk.decByte) begin
            sp_next = sp_reg - csv_pkg::STEP_BYTE;
        end else if (stk.incAddr) begin
            sp_next = sp_reg + csv_pkg::STEP_ADDR;
        end else if (stk.incByte) begin
            sp_next = sp_reg + csv_pkg::STEP_BYTE;
        end
    end

    // zero after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp_reg <= csv_pkg::SP_RESET;
        end else begin
            sp_reg <= sp_next;
        end
    end

    assign stk.sp = sp_reg;

    property p_pop_byte;
        @(posedge clk) disable iff (!rst_n)
        (stk.incByte && !stk.wrEn && !stk.decAddr && !stk.decByte && !stk.incAddr)
            |=> sp_reg == $past(sp_reg) + 8'h01;
    endproperty
    a_pop_byte: assert property (p_pop_byte) else $error("byte pop did not add one");

    property p_pop_addr;
        @(posedge clk) disable iff (!rst_n)
        (stk.incAddr && !stk.wrEn && !stk.decAddr && !stk.decByte)
            |=> sp_reg == $past(sp_reg) + 8'h02;
    endproperty
    a_pop_addr: assert property (p_pop_addr) else $error("address pop did not add two");

    property p_push_byte;
        @(posedge clk) disable iff (!rst_n)
        (stk.decByte && !stk.wrEn && !stk.decAddr) |=> sp_reg == $past(sp_reg) - 8'h01;
    endproperty
    a_push_byte: assert property (p_push_byte) else $error("byte push did not subtract one");
endmodule

// ===== rtl/csv_prio_pick.sv
// Purpose: fixed-priority pick of the lowest numbered enabled request
// Assumes: requests and enables are levels on the core clock
// Notes:   purely combinational; the core registers the result
`timescale 1ns/1ps
module csv_prio_pick #(
    parameter int N     = 13,
    parameter int IDX_W = 4
) (
    // requests and enables
    input  wire logic [N-1:0]     req,
    input  wire logic [N-1:0]     en,
    input  wire logic             gate,
    // pick
    output logic                  valid,
    output logic [IDX_W-1:0]      index,
    output logic [N-1:0]          pending
);
    // a source counts only with its own enable and the global gate
    for (genvar g = 0; g < N; g++) begin : gen_gate
        assign pending[g] = req[g] & en[g] & gate;
    end

    // scan from the top so the lowest index is the last to win
    always_comb begin
        valid = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                valid = 1'b1;
                index = IDX_W'(i);
            end
        end
    end
endmodule

// ===== rtl/csv_core.sv
// Purpose: flag word, stack pointer and interrupt vectoring of the core
// Assumes: decoder events are one-cycle pulses on clk; sources are synchronous
// Notes:   I/O reads answer one cycle after the read strobe
//
// What this block does
// - take an interrupt only with global gate bit 7 and source enable set
// - taking an interrupt clears the gate; interrupt return sets it again
// - bit 6 is the copy store for bit-store and bit-load instructions
// - bit 4 always equals negative flag xor overflow flag
// - carry in bit 0, half carry in bit 5, overflow in bit 3
// - bit 1 set on zero result, bit 2 on negative result
// - flag word at I/O $3F, all bits but sign bit 4 read/write, zero after reset
// - 8-bit stack pointer at I/O $3D, read/write, zero after reset
// - byte push subtracts one; call or interrupt entry subtracts two
// - byte pop adds one; subroutine or interrupt return adds two
// - thirteen sources plus reset, each with own vector; each source also has its own enable, reset has none
// - lowest vector wins; reset first, then external request zero
// - vector $000 serves every reset cause
// - vectors $001 to $00D follow the fixed source order
// - any reset restores registers and fetches from address zero
`timescale 1ns/1ps
module csv_core #(
    parameter int NSRC = csv_pkg::NUM_SOURCES
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // I/O register port
    input  wire logic [5:0]               ioAddr,
    input  wire logic                     ioWrEn,
    input  wire logic [7:0]               ioWrData,
    input  wire logic                     ioRdEn,
    output logic [7:0]                    ioRdData,
    // arithmetic results
    input  wire logic [7:0]               aluResult,
    input  wire logic                     aluCarry,
    input  wire logic                     aluHalf,
    input  wire logic                     aluOverflow,
    input  wire logic                     updCarry,
    input  wire logic                     updHalf,
    input  wire logic                     updOverflow,
    input  wire logic                     updZero,
    input  wire logic                     updNeg,
    // bit copy
    input  wire logic                     bitStoreEn,
    input  wire logic                     bitStoreValue,
    output logic                          bitLoadValue,
    // decoder stack events
    input  wire logic                     pushByte,
    input  wire logic                     popByte,
    input  wire logic                     callPush,
    input  wire logic                     subReturn,
    input  wire logic                     intReturn,
    // interrupt sources
    input  wire logic [NSRC-1:0]          irqReq,
    input  wire logic [NSRC-1:0]          irqEn,
    input  wire logic                     takeOk,
    input  wire logic [csv_pkg::PC_W-1:0] nextPc,
    // fetch redirection and state
    output logic                          jumpValid,
    output logic [csv_pkg::PC_W-1:0]      jumpAddr,
    output logic                          intTaken,
    output logic [csv_pkg::PC_W-1:0]      retAddrPush,
    output logic [7:0]                    flagWord,
    output logic [7:0]                    stackPointer
);
    localparam int IDX_W = $clog2(NSRC);

    csv_stack_if stk ();

    csv_pkg::csv_state_type     state_reg;
    csv_pkg::csv_state_type     state_next;
    logic [7:0]                 flag_reg;
    logic [7:0]                 flag_next;
    logic [7:0]                 rd_reg;
    logic [7:0]                 rd_next;
    logic                       jump_reg;
    logic                       jump_next;
    logic [csv_pkg::PC_W-1:0]   jaddr_reg;
    logic [csv_pkg::PC_W-1:0]   jaddr_next;
    logic                       taken_reg;
    logic                       taken_next;
    logic [csv_pkg::PC_W-1:0]   ret_reg;
    logic [csv_pkg::PC_W-1:0]   ret_next;
    logic                       pickValid;
    logic [IDX_W-1:0]           pickIndex;
    logic [NSRC-1:0]            pending;
    logic                       takeNow;
    logic                       flagWrite;
    logic                       spWrite;

    // priority pick across the enabled, gated sources
    csv_prio_pick #(
        .N     (NSRC),
        .IDX_W (IDX_W)
    ) u_pick (
        .req     (irqReq),
        .en      (irqEn),
        .gate    (flag_reg[csv_pkg::BIT_GATE]),
        .valid   (pickValid),
        .index   (pickIndex),
        .pending (pending)
    );

    // stack pointer unit
    csv_stack_ptr u_stack (
        .clk   (clk),
        .rst_n (rst_n),
        .stk   (stk.stack)
    );

    // decode of register writes
    assign flagWrite = ioWrEn && (ioAddr == csv_pkg::ADDR_FLAG_WORD);
    assign spWrite   = ioWrEn && (ioAddr == csv_pkg::ADDR_STACK_PTR);

    // interrupts are taken only at an instruction boundary once running
    assign takeNow = pickValid && takeOk && (state_reg == csv_pkg::CS_RUN);

    // stack moves; interrupt entry pushes a return address like a call
    assign stk.wrEn    = spWrite;
    assign stk.wrData  = ioWrData;
    assign stk.decByte = pushByte;
    assign stk.decAddr = callPush || takeNow;
    assign stk.incByte = popByte;
    assign stk.incAddr = subReturn || intReturn;

    // flag word next value; later steps override earlier ones
    always_comb begin
        flag_next = flag_reg;
        if (flagWrite) begin
            flag_next = ioWrData;
        end
        if (updCarry) begin
            flag_next[csv_pkg::BIT_CARRY] = aluCarry;
        end
        if (updHalf) begin
            flag_next[csv_pkg::BIT_HALF] = aluHalf;
        end
        if (updOverflow) begin
            flag_next[csv_pkg::BIT_OVER] = aluOverflow;
        end
        if (updZero) begin
            flag_next[csv_pkg::BIT_ZERO] = (aluResult == 8'h00);
        end
        if (updNeg) begin
            flag_next[csv_pkg::BIT_NEG] = aluResult[7];
        end
        if (bitStoreEn) begin
            flag_next[csv_pkg::BIT_COPY] = bitStoreValue;
        end
        // sign is never stored independently, even by a software write
        flag_next[csv_pkg::BIT_SIGN] = flag_next[csv_pkg::BIT_NEG] ^ flag_next[csv_pkg::BIT_OVER];
        if (intReturn) begin
            flag_next[csv_pkg::BIT_GATE] = 1'b1;
        end
        // hardware clear last: an interrupt return in the same cycle cannot reopen the gate
        if (takeNow) begin
            flag_next[csv_pkg::BIT_GATE] = 1'b0;
        end
    end

    // read mux; unmapped locations read as zero
    always_comb begin
        rd_next = rd_reg;
        if (ioRdEn) begin
            if (ioAddr == csv_pkg::ADDR_FLAG_WORD) begin
                rd_next = flag_reg;
            end else if (ioAddr == csv_pkg::ADDR_STACK_PTR) begin
                rd_next = stk.sp;
            end else begin
                rd_next = csv_pkg::READ_NONE;
            end
        end
    end

    // sequencing: one restart fetch after reset, then vectoring
    always_comb begin
        state_next = state_reg;
        jump_next  = 1'b0;
        jaddr_next = jaddr_reg;
        taken_next = 1'b0;
        ret_next   = ret_reg;
        unique case (state_reg)
            csv_pkg::CS_RESTART: begin
                jump_next  = 1'b1;
                jaddr_next = csv_pkg::VEC_RESET;
                state_next = csv_pkg::CS_RUN;
            end
            csv_pkg::CS_RUN: begin
                if (takeNow) begin
                    jump_next  = 1'b1;
                    taken_next = 1'b1;
                    // vector order follows source index, one word each
                    jaddr_next = csv_pkg::VEC_FIRST + csv_pkg::PC_W'(pickIndex);
                    ret_next   = nextPc;
                end
            end
        endcase
    end

    // registers; all return to their initial values on reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= csv_pkg::CS_RESTART;
            flag_reg  <= csv_pkg::FLAG_RESET;
            rd_reg    <= csv_pkg::READ_NONE;
            jump_reg  <= 1'b0;
            jaddr_reg <= csv_pkg::VEC_RESET;
            taken_reg <= 1'b0;
            ret_reg   <= csv_pkg::VEC_RESET;
        end else begin
            state_reg <= state_next;
            flag_reg  <= flag_next;
            rd_reg    <= rd_next;
            jump_reg  <= jump_next;
            jaddr_reg <= jaddr_next;
            taken_reg <= taken_next;
            ret_reg   <= ret_next;
        end
    end

    // outputs, all straight from flops
    assign ioRdData     = rd_reg;
    assign bitLoadValue = flag_reg[csv_pkg::BIT_COPY];
    assign jumpValid    = jump_reg;
    assign jumpAddr     = jaddr_reg;
    assign intTaken     = taken_reg;
    assign retAddrPush  = ret_reg;
    assign flagWord     = flag_reg;
    assign stackPointer = stk.sp;

    // helper: sources with vectors below the taken vector, and the one source it belongs to
    logic [NSRC-1:0] higherMask;
    logic [NSRC-1:0] jumpSel;
    always_comb begin
        higherMask = '0;
        jumpSel    = '0;
        for (int i = 0; i < NSRC; i++) begin
            higherMask[i] = (csv_pkg::VEC_FIRST + csv_pkg::PC_W'(i)) < jaddr_reg;
            jumpSel[i]    = (csv_pkg::VEC_FIRST + csv_pkg::PC_W'(i)) == jaddr_reg;
        end
    end

    sequence s_take;
        takeNow && !spWrite;
    endsequence

    sequence s_entered;
        intTaken && jumpValid && !flagWord[7];
    endsequence

    property p_gate_needed;
        @(posedge clk) disable iff (!rst_n)
        intTaken |-> $past(flagWord[7]) && $past(takeOk);
    endproperty
    a_gate_needed: assert property (p_gate_needed) else $error("interrupt taken with gate closed");

    property p_enable_needed;
        @(posedge clk) disable iff (!rst_n)
        intTaken |-> ($past(irqEn) & $past(irqReq) & jumpSel) != '0;
    endproperty
    a_enable_needed: assert property (p_enable_needed) else $error("vector of a disabled source");

    property p_entry;
        @(posedge clk) disable iff (!rst_n)
        s_take |=> s_entered ##0 (stackPointer == $past(stackPointer) - 8'h02);
    endproperty
    a_entry: assert property (p_entry) else $error("interrupt entry sequence wrong");

    property p_return_gate;
        @(posedge clk) disable iff (!rst_n)
        (intReturn && !takeNow) |=> flagWord[7];
    endproperty
    a_return_gate: assert property (p_return_gate) else $error("interrupt return left gate closed");

    property p_copy_store;
        @(posedge clk) disable iff (!rst_n)
        (bitStoreEn && !flagWrite) |=> bitLoadValue == $past(bitStoreValue);
    endproperty
    a_copy_store: assert property (p_copy_store) else $error("copy bit not stored");

    property p_sign;
        @(posedge clk) disable iff (!rst_n)
        flagWord[4] == (flagWord[2] ^ flagWord[3]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign bit not negative xor overflow");

    property p_zero_neg;
        @(posedge clk) disable iff (!rst_n)
        (updZero && updNeg) |=> flagWord[1] == ($past(aluResult) == 8'h00) && flagWord[2] == $past(aluResult[7]);
    endproperty
    a_zero_neg: assert property (p_zero_neg) else $error("zero or negative flag wrong");

    property p_priority;
        @(posedge clk) disable iff (!rst_n)
        intTaken |-> ($past(pending) & higherMask) == '0;
    endproperty
    a_priority: assert property (p_priority) else $error("lower priority source served first");

    property p_restart;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> flagWord == 8'h00 && stackPointer == 8'h00 ##1 jumpValid && jumpAddr == 12'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("reset did not restart at zero");

    property p_read_flags;
        @(posedge clk) disable iff (!rst_n)
        (ioRdEn && ioAddr == 6'h3F) |=> ioRdData == $past(flagWord);
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag word read wrong");
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the flag word, stack pointer and vectoring core
// Assumes: pulses last one clock; outputs are checked 1 ns after the edge that loads them
// Notes:   register and flag traffic runs from a table; interrupts and resets are hand-written
`timescale 1ns/1ps
module tb;
    // operation kinds of a table row
    localparam logic [2:0] K_WR = 3'h0, K_RD = 3'h1, K_PUSH = 3'h2, K_POP = 3'h3;
    localparam logic [2:0] K_CALL = 3'h4, K_SRET = 3'h5, K_ALU = 3'h6, K_BST = 3'h7;
    // for an ALU row, addr[0] is carry, addr[1] half carry, addr[2] overflow
    typedef struct packed {
        logic [2:0] kind;
        logic [5:0] addr;
        logic [7:0] data;
        logic [7:0] expFlag;
        logic [7:0] expSp;
        logic [7:0] expRd;
    } csv_row_type;

    logic        clk, rst_n, ioWrEn, ioRdEn, bitStoreEn, bitStoreValue, takeOk;
    logic        aluCarry, aluHalf, aluOverflow, updCarry, updHalf, updOverflow, updZero, updNeg;
    logic        pushByte, popByte, callPush, subReturn, intReturn;
    logic [5:0]  ioAddr;
    logic [7:0]  ioWrData, aluResult, ioRdData, flagWord, stackPointer;
    logic [12:0] irqReq, irqEn;
    logic [11:0] nextPc, jumpAddr, retAddrPush, pcVal;
    logic        bitLoadValue, jumpValid, intTaken;
    int          errors, checks, cycles, i;
    csv_row_type rows [0:18];

    csv_core u_dut (
        .clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioWrData(ioWrData),
        .ioRdEn(ioRdEn), .ioRdData(ioRdData), .aluResult(aluResult), .aluCarry(aluCarry),
        .aluHalf(aluHalf), .aluOverflow(aluOverflow), .updCarry(updCarry), .updHalf(updHalf),
        .updOverflow(updOverflow), .updZero(updZero), .updNeg(updNeg), .bitStoreEn(bitStoreEn),
        .bitStoreValue(bitStoreValue), .bitLoadValue(bitLoadValue), .pushByte(pushByte),
        .popByte(popByte), .callPush(callPush), .subReturn(subReturn), .intReturn(intReturn),
        .irqReq(irqReq), .irqEn(irqEn), .takeOk(takeOk), .nextPc(nextPc), .jumpValid(jumpValid),
        .jumpAddr(jumpAddr), .intTaken(intTaken), .retAddrPush(retAddrPush), .flagWord(flagWord),
        .stackPointer(stackPointer)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard; the whole run needs well under 300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t run did not finish in time", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk12(input string what, input logic [11:0] got, input logic [11:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // drop every pulse and level back to quiet; rst_n is left alone
    task automatic idle();
        {ioWrEn, ioRdEn, bitStoreEn, bitStoreValue, takeOk, pushByte, popByte} <= 7'h00;
        {callPush, subReturn, intReturn, aluCarry, aluHalf, aluOverflow} <= 6'h00;
        {updCarry, updHalf, updOverflow, updZero, updNeg} <= 5'h00;
        ioAddr <= 6'h00;
        ioWrData <= 8'h00;
        aluResult <= 8'h00;
        irqReq <= 13'h0000;
        irqEn <= 13'h0000;
        nextPc <= 12'h000;
    endtask

    // one request pulse, then settle past the edge that takes it
    task automatic apply(input csv_row_type r);
        @(posedge clk);
        case (r.kind)
            K_WR: begin
                ioWrEn <= 1'b1;
                ioAddr <= r.addr;
                ioWrData <= r.data;
            end
            K_RD: begin
                ioRdEn <= 1'b1;
                ioAddr <= r.addr;
            end
            K_PUSH: pushByte <= 1'b1;
            K_POP: popByte <= 1'b1;
            K_CALL: callPush <= 1'b1;
            K_SRET: subReturn <= 1'b1;
            K_ALU: begin
                aluResult <= r.data;
                {aluOverflow, aluHalf, aluCarry} <= r.addr[2:0];
                {updCarry, updHalf, updOverflow, updZero, updNeg} <= 5'h1F;
            end
            default: begin
                bitStoreEn <= 1'b1;
                bitStoreValue <= r.data[0];
            end
        endcase
        @(posedge clk);
        idle();
        #1;
    endtask

    // offer an interrupt for one instruction boundary
    task automatic take(input logic [12:0] req, input logic [12:0] en, input logic [11:0] pc);
        @(posedge clk);
        irqReq <= req;
        irqEn <= en;
        nextPc <= pc;
        takeOk <= 1'b1;
        @(posedge clk);
        idle();
        #1;
    endtask

    // hold reset low, check the cleared state, release and see the restart fetch
    task automatic do_reset(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        chk8("flagWord", flagWord, 8'h00);
        chk8("stackPointer", stackPointer, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk8("jumpValid", {7'h00, jumpValid}, 8'h01);
        chk12("jumpAddr", jumpAddr, 12'h000);
    endtask

    initial begin
        errors = 0;
        checks = 0;
        cycles = 0;
        rst_n <= 1'b0;
        idle();
        rows = '{
            '{K_WR, 6'h3D, 8'h80, 8'h00, 8'h80, 8'h00},
            '{K_RD, 6'h3D, 8'h00, 8'h00, 8'h80, 8'h80},
            '{K_PUSH, 6'h00, 8'h00, 8'h00, 8'h7F, 8'h00},
            '{K_CALL, 6'h00, 8'h00, 8'h00, 8'h7D, 8'h00},
            '{K_POP, 6'h00, 8'h00, 8'h00, 8'h7E, 8'h00},
            '{K_SRET, 6'h00, 8'h00, 8'h00, 8'h80, 8'h00},
            '{K_WR, 6'h3F, 8'hFF, 8'hEF, 8'h80, 8'h00},
            '{K_RD, 6'h3F, 8'h00, 8'hEF, 8'h80, 8'hEF},
            '{K_WR, 6'h3F, 8'h00, 8'h00, 8'h80, 8'h00},
            '{K_WR, 6'h3E, 8'h55, 8'h00, 8'h80, 8'h00},
            '{K_RD, 6'h3E, 8'h00, 8'h00, 8'h80, 8'h00},
            '{K_ALU, 6'h05, 8'h00, 8'h1B, 8'h80, 8'h00},
            '{K_ALU, 6'h02, 8'h80, 8'h34, 8'h80, 8'h00},
            '{K_ALU, 6'h05, 8'h80, 8'h0D, 8'h80, 8'h00},
            '{K_BST, 6'h00, 8'h01, 8'h4D, 8'h80, 8'h00},
            '{K_BST, 6'h00, 8'h00, 8'h0D, 8'h80, 8'h00},
            '{K_WR, 6'h3D, 8'h61, 8'h0D, 8'h61, 8'h00},
            '{K_CALL, 6'h00, 8'h00, 8'h0D, 8'h5F, 8'h00},
            '{K_WR, 6'h3D, 8'h90, 8'h0D, 8'h90, 8'h00}
        };
        do_reset(10);
        // ordinary register, stack and flag traffic
        foreach (rows[k]) begin
            apply(rows[k]);
            chk8("flagWord", flagWord, rows[k].expFlag);
            chk8("stackPointer", stackPointer, rows[k].expSp);
            chk8("bitLoadValue", {7'h00, bitLoadValue}, {7'h00, rows[k].expFlag[6]});
            if (rows[k].kind == K_RD) begin
                chk8("ioRdData", ioRdData, rows[k].expRd);
            end
        end
        // closed gate: every source requested and enabled, nothing may happen
        take(13'h1FFF, 13'h1FFF, 12'h0AA);
        chk8("intTaken", {7'h00, intTaken}, 8'h00);
        chk8("stackPointer", stackPointer, 8'h90);
        apply('{K_WR, 6'h3F, 8'h8D, 8'h00, 8'h00, 8'h00});
        // each source in turn wins; the one below it is requested but not enabled
        for (i = 0; i < 13; i++) begin
            pcVal = 12'h100 + 12'(i);
            take(13'h1FFF << ((i == 0) ? 0 : i - 1),
                 (i == 0) ? 13'h1FFF : ~(13'h0001 << (i - 1)), pcVal);
            chk8("intTaken", {7'h00, intTaken}, 8'h01);
            chk8("jumpValid", {7'h00, jumpValid}, 8'h01);
            chk12("jumpAddr", jumpAddr, 12'(i + 1));
            chk12("retAddrPush", retAddrPush, pcVal);
            chk8("flagWord", flagWord, 8'h0D);
            chk8("stackPointer", stackPointer, 8'h8E);
            // handler saves the flag word, disturbs it, then restores it itself
            apply('{K_RD, 6'h3F, 8'h00, 8'h00, 8'h00, 8'h00});
            apply('{K_ALU, 6'h00, 8'h00, 8'h00, 8'h00, 8'h00});
            apply('{K_WR, 6'h3F, ioRdData, 8'h00, 8'h00, 8'h00});
            chk8("flagWord", flagWord, 8'h0D);
            @(posedge clk);
            intReturn <= 1'b1;
            @(posedge clk);
            idle();
            #1;
            chk8("flagWord", flagWord, 8'h8D);
            chk8("stackPointer", stackPointer, 8'h90);
            chk8("intTaken", {7'h00, intTaken}, 8'h00);
        end
        // reset in mid-run clears everything and restarts at vector zero
        do_reset(2);
        wrap_up();
    end
endmodule
